// ---- dpfs_defs.vh ----
// Constants for the debug port pin function select block
// Functional notes
// RL1 - SPI slave mode takes data input from pin
// RL2 - Two-wire clock open-drain, needs remap clear or timer off
// RL3 - UART mode takes receive data from pin
// RL4 - Timer2 ch2 output needs remap, enable, alt
// RL5 - Timer2 ch2 capture from pin when remapped
// RL6 - JTAG mode after power-up or reset low
// RL7 - Debugger switch sequence moves pins to serial-wire
// RL8 - Clock pin: serial-wire clock or JTAG clock
// RL9 - Port C bit2 drives JTAG data out
// RL10 - Async trace on C2 needs four conditions
// RL11 - Port C bit3 GPIO or JTAG data in
// RL12 - Port C bit4 carries JTAG mode select
// RL13 - Mode select pin becomes bidirectional serial-wire data
// RL14 - Sync trace clock on B0 when enabled, alt
// RL15 - B0 feeds interrupt A, timer clocks
// RL16 - B0 analog field connects ADC reference
// RL17 - C1 carries async trace when selected, alt
// RL18 - C1 carries sync trace bit zero
// RL19 - C1 analog field connects ADC input 3
// RL20 - C0 GPIO when released or serial-wire without bit1
// RL21 - C0 JTAG reset in JTAG without bit1
// RL22 - Pulls enabled while debug owns its pins; the clock pull-down follows JTAG mode alone, even when pins are released
// RL23 - Interrupts C and D selectable to any pin
// RL24 - Output priority: debug, alternate, then GPIO; analog fields on B0 and C1 take priority over all
`ifndef DPFS_DEFS_VH
`define DPFS_DEFS_VH

// ------------------------------------------------------------
// Pin indexes in the shared pin vectors
// ------------------------------------------------------------
`define DPFS_PIN_B0          3'h0
`define DPFS_PIN_B2          3'h1
`define DPFS_PIN_C0          3'h2
`define DPFS_PIN_C1          3'h3
`define DPFS_PIN_C2          3'h4
`define DPFS_PIN_C3          3'h5
`define DPFS_PIN_C4          3'h6
`define DPFS_NUM_PINS        7
`define DPFS_SYNC_W          10

// ------------------------------------------------------------
// Config field positions (nibble index) and codes
// ------------------------------------------------------------
`define DPFS_FLD_B0          2'h0
`define DPFS_FLD_B2          2'h2
`define DPFS_FLD_C0          2'h0
`define DPFS_FLD_C1          2'h1
`define DPFS_FLD_C2          2'h2
`define DPFS_CFG_ANALOG      4'h0
`define DPFS_CFG_ALT_OUT     4'h9
`define DPFS_CFG_ALT_OD      4'hd
`define DPFS_CFG_RESET       16'h4444

// ------------------------------------------------------------
// Serial controller modes and trace modes
// ------------------------------------------------------------
`define DPFS_SC_OFF          2'h0
`define DPFS_SC_UART         2'h1
`define DPFS_SC_SPI          2'h2
`define DPFS_SC_TWI          2'h3
`define DPFS_TR_ASYNC        2'h0
`define DPFS_TR_SYNC1        2'h1
`define DPFS_TR_SYNC2        2'h2
`define DPFS_TR_SYNC4        2'h3

// ------------------------------------------------------------
// Debug port switching sequences, sent LSB first
// ------------------------------------------------------------
`define DPFS_SEQ_TO_SWD      16'he79e
`define DPFS_SEQ_TO_JTAG     16'he73c
`define DPFS_SEQ_LEAD_ONES   6'h32

`endif

// ---- dpfs_sync.v ----
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module dpfs_sync
#(
	parameter W = 1
)
(
	input  wire         clk_sys, // System clock
	input  wire         rst_n,   // Async reset, active low
	input  wire         ce,      // Clock enable
	input  wire [W-1:0] d,       // Asynchronous inputs
	output reg  [W-1:0] q        // Synchronised outputs
);

	reg [W-1:0] meta;

	// First stage feeds only the second
	always @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta <= {W{1'b0}};
			q    <= {W{1'b0}};
		end
		else if (ce)
		begin
			meta <= d;
			q    <= meta;
		end
	end

endmodule

// ---- dpfs_top.v ----
// Pin function selection for the shared debug and peripheral pins
`timescale 1ns/1ps
`include "dpfs_defs.vh"
module dpfs_top
(
	input  wire        clk_sys, // System clock, 50 MHz
	input  wire        rst_n, // Async reset, active low
	input  wire        ce, // Clock enable, freezes state when low
	// Pads
	input  wire [6:0]  pin_in, // Shared pin levels
	input  wire        debug_clock_pin_in, // Debug clock pin level
	input  wire        external_reset_low, // External reset pin, active low
	input  wire        ext_interrupt_c_default, // Default pin level for interrupt C
	output reg  [6:0]  pin_out, // Shared pin drive value
	output reg  [6:0]  pin_oe, // Shared pin drive enable
	output reg  [6:0]  pin_pull_up, // Shared pin pull-up enable
	output reg         debug_clock_pull_down, // Debug clock pin pull-down
	// Configuration
	input  wire [15:0] port_b_low_config, // Port B low config fields
	input  wire [15:0] port_c_low_config, // Port C low config fields
	input  wire        debug_pin_config, // Debug pins returned to GPIO
	input  wire        timer2_remap_option, // Timer2 channel 2 remap
	input  wire        timer2_channel_output_enable, // Timer2 channel 2 output on
	input  wire [1:0]  serial_ctl1_mode_select, // Serial controller 1 mode
	input  wire        serial_ctl1_spi_control, // SPI slave select, high is slave
	input  wire        trace_enable, // Trace interface enable
	input  wire [1:0]  trace_mode, // Async or 1/2/4-wire sync trace
	input  wire        irq_c_select_en, // Interrupt C taken from selected pin
	input  wire [2:0]  irq_c_select, // Pin index for interrupt C
	input  wire        irq_d_select_en, // Interrupt D taken from selected pin
	input  wire [2:0]  irq_d_select, // Pin index for interrupt D
	// Function sources
	input  wire [6:0]  gpio_out, // GPIO output values
	input  wire [6:0]  gpio_oe, // GPIO output enables
	input  wire        timer2_channel2_out, // Timer2 channel 2 output
	input  wire        serial_ctl1_twowire_release, // High lets clock line float
	input  wire        scan_test_data_out, // JTAG data out
	input  wire        scan_test_data_out_en, // JTAG data out enable
	input  wire        swd_data_out, // Serial-wire data out
	input  wire        swd_data_oe, // Serial-wire data drive turn
	input  wire        async_trace_out, // Async trace output
	input  wire        sync_trace_clock, // Sync trace clock
	input  wire        sync_trace_bit0, // Sync trace data bit 0
	input  wire        sync_trace_bit1, // Sync trace data bit 1
	// Function sinks
	output reg  [6:0]  gpio_in, // Synchronised pin levels
	output reg         serial_ctl1_slave_data_in, // SPI slave data in
	output reg         serial_ctl1_twowire_clock, // Two-wire clock sensed
	output reg         serial_ctl1_receive, // UART receive data
	output reg         timer2_channel2, // Timer2 channel 2 capture in
	output reg         scan_test_clock, // JTAG clock
	output reg         scan_test_data_in, // JTAG data in
	output reg         scan_test_mode_select, // JTAG mode select
	output reg         scan_test_reset, // JTAG reset level, low active
	output reg         swd_clock, // Serial-wire clock
	output reg         swd_data_in, // Serial-wire data in
	output reg         swd_mode_active, // Serial-wire mode selected
	output reg         ext_interrupt_a, // External interrupt A
	output reg         ext_interrupt_c, // External interrupt C
	output reg         ext_interrupt_d, // External interrupt D
	output reg         timer1_ext_clock, // Timer1 external clock
	output reg         timer2_clock_mask, // Timer2 clock mask
	output reg         adc_reference_select, // B0 on ADC reference
	output reg         converter_input_3 // C1 on ADC input 3
);

	// ------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------
	function [3:0] cfg_field;
		input [15:0] cfg;
		input [1:0]  idx;
		begin
			cfg_field = cfg[{idx, 2'b00} +: 4];
		end
	endfunction

	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	wire [9:0] sync_q;
	wire [6:0] pin_s;
	wire       clk_pin_s;
	wire       external_reset_low_s;
	wire       ext_interrupt_c_def_s;

	dpfs_sync #(.W(`DPFS_SYNC_W)) u_sync
	(
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.ce      (ce),
		.d       ({ext_interrupt_c_default, external_reset_low, debug_clock_pin_in, pin_in}),
		.q       (sync_q)
	);

	assign pin_s      = sync_q[6:0];
	assign clk_pin_s  = sync_q[7];
	assign external_reset_low_s   = sync_q[8];
	assign ext_interrupt_c_def_s = sync_q[9];

	// ------------------------------------------------------------
	// Debug mode selection
	// ------------------------------------------------------------
	// Clock pin is slow against clk_sys, so edges are found by sampling
	reg        swd_mode;
	reg        clk_pin_d;
	reg [15:0] seq_window;
	reg [5:0]  lead_ones;
	wire       clk_rise   = clk_pin_s & ~clk_pin_d;
	wire       tms_bit    = pin_s[`DPFS_PIN_C4];
	wire [15:0] next_window = {tms_bit, seq_window[15:1]};
	wire [5:0] next_ones  = !seq_window[0] ? 6'h00 :
	                        (lead_ones == `DPFS_SEQ_LEAD_ONES) ? lead_ones : lead_ones + 6'h01;
	wire       lead_ok    = (next_ones == `DPFS_SEQ_LEAD_ONES);

	always @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			swd_mode   <= 1'b0; // see RL6
			clk_pin_d  <= 1'b0;
			seq_window <= 16'h0000;
			lead_ones  <= 6'h00;
		end
		else if (ce)
		begin
			clk_pin_d <= clk_pin_s;
			if (!external_reset_low_s)
			begin
				swd_mode   <= 1'b0; // see RL6
				seq_window <= 16'h0000;
				lead_ones  <= 6'h00;
			end
			else if (clk_rise && !debug_pin_config)
			begin
				seq_window <= next_window;
				lead_ones  <= next_ones;
				if (lead_ok && next_window == `DPFS_SEQ_TO_SWD)
					swd_mode <= 1'b1;             // see RL7
				else if (lead_ok && next_window == `DPFS_SEQ_TO_JTAG)
					swd_mode <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Pin function decode
	// ------------------------------------------------------------
	wire       jtag_mode = ~swd_mode;
	wire       dbg_on    = ~debug_pin_config;
	wire [3:0] fld_b0    = cfg_field(port_b_low_config, `DPFS_FLD_B0);
	wire [3:0] fld_b2    = cfg_field(port_b_low_config, `DPFS_FLD_B2);
	wire [3:0] fld_c0    = cfg_field(port_c_low_config, `DPFS_FLD_C0);
	wire [3:0] fld_c1    = cfg_field(port_c_low_config, `DPFS_FLD_C1);
	wire [3:0] fld_c2    = cfg_field(port_c_low_config, `DPFS_FLD_C2);
	wire       tr_async  = trace_enable && trace_mode == `DPFS_TR_ASYNC;
	wire       tr_sync   = trace_enable && trace_mode != `DPFS_TR_ASYNC;
	wire       tr_bit1   = trace_enable && (trace_mode == `DPFS_TR_SYNC2 ||
	                                        trace_mode == `DPFS_TR_SYNC4);
	wire       sc_spi    = serial_ctl1_mode_select == `DPFS_SC_SPI;
	wire       sc_uart   = serial_ctl1_mode_select == `DPFS_SC_UART;
	wire       sc_twi    = serial_ctl1_mode_select == `DPFS_SC_TWI;

	// B2: timer output and two-wire clock
	wire t2_out_on  = timer2_remap_option && timer2_channel_output_enable &&
	                  fld_b2 == `DPFS_CFG_ALT_OUT; // see RL4
	wire twi_clk_on = sc_twi && fld_b2 == `DPFS_CFG_ALT_OD &&
	                  (!timer2_channel_output_enable || !timer2_remap_option); // see RL2
	// C2: JTAG data out or async trace
	wire tdo_on     = jtag_mode && dbg_on; // see RL9
	wire swo_c2_on  = swd_mode && tr_async && fld_c2 == `DPFS_CFG_ALT_OUT; // see RL10
	// C3 and C4
	wire tdi_on     = jtag_mode && dbg_on; // see RL11
	wire tms_on     = jtag_mode && dbg_on; // see RL12
	wire swdio_on   = swd_mode && dbg_on; // see RL13
	// B0 and C1
	wire b0_analog  = fld_b0 == `DPFS_CFG_ANALOG; // see RL16
	wire tclk_on    = trace_enable && fld_b0 == `DPFS_CFG_ALT_OUT; // see RL14
	wire c1_analog  = fld_c1 == `DPFS_CFG_ANALOG; // see RL19
	wire swo_c1_on  = tr_async && fld_c1 == `DPFS_CFG_ALT_OUT; // see RL17
	wire td0_on     = tr_sync && fld_c1 == `DPFS_CFG_ALT_OUT; // see RL18
	// C0: JTAG reset or trace bit 1
	wire scan_test_reset_on    = jtag_mode && dbg_on && !tr_bit1; // see RL21
	wire td1_on     = tr_bit1 && fld_c0 == `DPFS_CFG_ALT_OUT;

	reg [6:0] next_out;
	reg [6:0] next_oe;
	reg [6:0] next_pu;

	// Debug first, then alternate, then GPIO; the B0 and C1 analog fields override all three
	always @*
	begin
		next_out = gpio_out; // see RL24
		next_oe  = gpio_oe;
		next_pu  = 7'h00;
		// B0
		if (b0_analog)
		begin
			next_out[`DPFS_PIN_B0] = 1'b0;
			next_oe[`DPFS_PIN_B0]  = 1'b0;
		end
		else if (tclk_on)
		begin
			next_out[`DPFS_PIN_B0] = sync_trace_clock;
			next_oe[`DPFS_PIN_B0]  = 1'b1;
		end
		// B2, clock line only ever pulled low
		if (t2_out_on)
		begin
			next_out[`DPFS_PIN_B2] = timer2_channel2_out;
			next_oe[`DPFS_PIN_B2]  = 1'b1;
		end
		else if (twi_clk_on)
		begin
			next_out[`DPFS_PIN_B2] = 1'b0; // see RL2
			next_oe[`DPFS_PIN_B2]  = ~serial_ctl1_twowire_release;
		end
		// C0, stays GPIO when released or in serial-wire without bit 1
		if (scan_test_reset_on)
		begin
			next_oe[`DPFS_PIN_C0] = 1'b0;
			next_pu[`DPFS_PIN_C0] = 1'b1; // see RL22
		end
		else if (td1_on)
		begin
			next_out[`DPFS_PIN_C0] = sync_trace_bit1;
			next_oe[`DPFS_PIN_C0]  = 1'b1;
		end // see RL20
		// C1
		if (c1_analog)
		begin
			next_out[`DPFS_PIN_C1] = 1'b0;
			next_oe[`DPFS_PIN_C1]  = 1'b0;
		end
		else if (swo_c1_on)
		begin
			next_out[`DPFS_PIN_C1] = async_trace_out;
			next_oe[`DPFS_PIN_C1]  = 1'b1;
			next_pu[`DPFS_PIN_C1]  = 1'b1; // see RL22
		end
		else if (td0_on)
		begin
			next_out[`DPFS_PIN_C1] = sync_trace_bit0;
			next_oe[`DPFS_PIN_C1]  = 1'b1;
		end
		// C2
		if (tdo_on)
		begin
			next_out[`DPFS_PIN_C2] = scan_test_data_out;
			next_oe[`DPFS_PIN_C2]  = scan_test_data_out_en;
		end
		else if (swo_c2_on)
		begin
			next_out[`DPFS_PIN_C2] = async_trace_out;
			next_oe[`DPFS_PIN_C2]  = 1'b1;
			next_pu[`DPFS_PIN_C2]  = 1'b1; // see RL22
		end
		// C3
		if (tdi_on)
		begin
			next_oe[`DPFS_PIN_C3] = 1'b0;
			next_pu[`DPFS_PIN_C3] = 1'b1; // see RL22
		end
		// C4
		if (tms_on)
		begin
			next_oe[`DPFS_PIN_C4] = 1'b0;
			next_pu[`DPFS_PIN_C4] = 1'b1; // see RL22
		end
		else if (swdio_on)
		begin
			next_out[`DPFS_PIN_C4] = swd_data_out; // see RL13
			next_oe[`DPFS_PIN_C4]  = swd_data_oe;
			next_pu[`DPFS_PIN_C4]  = 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Output registers
	// ------------------------------------------------------------
	// Idle levels chosen so unselected receivers see an idle line
	always @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pin_out                   <= 7'h00;
			pin_oe                    <= 7'h00;
			pin_pull_up               <= 7'h00;
			debug_clock_pull_down     <= 1'b0;
			gpio_in                   <= 7'h00;
			serial_ctl1_slave_data_in <= 1'b0;
			serial_ctl1_twowire_clock <= 1'b1;
			serial_ctl1_receive       <= 1'b1;
			timer2_channel2           <= 1'b0;
			scan_test_clock           <= 1'b0;
			scan_test_data_in         <= 1'b1;
			scan_test_mode_select     <= 1'b1;
			scan_test_reset           <= 1'b1;
			swd_clock                 <= 1'b0;
			swd_data_in               <= 1'b1;
			swd_mode_active           <= 1'b0;
			ext_interrupt_a           <= 1'b0;
			ext_interrupt_c           <= 1'b0;
			ext_interrupt_d           <= 1'b0;
			timer1_ext_clock          <= 1'b0;
			timer2_clock_mask         <= 1'b0;
			adc_reference_select      <= 1'b0;
			converter_input_3         <= 1'b0;
		end
		else if (ce)
		begin
			pin_out                   <= next_out;
			pin_oe                    <= next_oe;
			pin_pull_up               <= next_pu;
			debug_clock_pull_down     <= jtag_mode; // see RL22
			gpio_in                   <= pin_s;
			serial_ctl1_slave_data_in <= (sc_spi && serial_ctl1_spi_control) ?
			                             pin_s[`DPFS_PIN_B2] : 1'b0;            // see RL1
			serial_ctl1_twowire_clock <= twi_clk_on ? pin_s[`DPFS_PIN_B2] : 1'b1;
			serial_ctl1_receive       <= sc_uart ? pin_s[`DPFS_PIN_B2] : 1'b1; // see RL3
			timer2_channel2           <= timer2_remap_option ?
			                             pin_s[`DPFS_PIN_B2] : 1'b0;            // see RL5
			scan_test_clock           <= jtag_mode ? clk_pin_s : 1'b0; // see RL8
			swd_clock                 <= swd_mode ? clk_pin_s : 1'b0; // see RL8
			scan_test_data_in         <= tdi_on ? pin_s[`DPFS_PIN_C3] : 1'b1;   // see RL11
			scan_test_mode_select     <= tms_on ? pin_s[`DPFS_PIN_C4] : 1'b1;   // see RL12
			swd_data_in               <= swdio_on ? pin_s[`DPFS_PIN_C4] : 1'b1; // see RL13
			scan_test_reset           <= scan_test_reset_on ? pin_s[`DPFS_PIN_C0] : 1'b1;  // see RL21
			swd_mode_active           <= swd_mode;
			ext_interrupt_a           <= pin_s[`DPFS_PIN_B0]; // see RL15
			timer1_ext_clock          <= pin_s[`DPFS_PIN_B0]; // see RL15
			timer2_clock_mask         <= pin_s[`DPFS_PIN_B0]; // see RL15
			ext_interrupt_c           <= irq_c_select_en ?
			                             pin_s[irq_c_select] : ext_interrupt_c_def_s;      // see RL23
			ext_interrupt_d           <= irq_d_select_en ?
			                             pin_s[irq_d_select] : pin_s[`DPFS_PIN_C0]; // see RL23
			adc_reference_select      <= b0_analog; // see RL16
			converter_input_3         <= c1_analog; // see RL19
		end
	end

endmodule

// ---- dpfs_monitor.sv ----
// Concurrent checks on the ports of the pin function select block
`timescale 1ns/1ps
module dpfs_monitor
(
	input wire logic        clk_sys, // Clock
	input wire logic        rst_n, // Reset, low active
	input wire logic        ce, // Clock enable
	input wire logic        external_reset_low, // Reset pad
	input wire logic        debug_clock_pin_in, // Debug clock pad
	input wire logic [6:0]  pin_out, // Pad values
	input wire logic [6:0]  pin_oe, // Pad enables
	input wire logic [6:0]  pin_pull_up, // Pad pull-ups
	input wire logic        debug_clock_pull_down, // Clock pad pull-down
	input wire logic [15:0] port_b_low_config, // Port B fields
	input wire logic        debug_pin_config, // Debug pins released
	input wire logic        timer2_remap_option, // Remap bit
	input wire logic        timer2_channel_output_enable, // Channel enable
	input wire logic [1:0]  serial_ctl1_mode_select, // Serial mode
	input wire logic        serial_ctl1_twowire_release, // Clock line float
	input wire logic        timer2_channel2_out, // Timer output
	input wire logic        scan_test_data_out, // Scan data out
	input wire logic        scan_test_data_out_en, // Scan data enable
	input wire logic        swd_data_oe, // Wire data turn
	input wire logic        swd_mode_active, // Wire mode
	input wire logic        swd_clock, // Wire clock sink
	input wire logic        scan_test_clock, // Scan clock sink
	input wire logic        adc_reference_select // Reference select
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// Consecutive edges with ce high, cleared by ce low, saturating at 3; $past is only trusted once this is non-zero
	logic [1:0] up;
	always_ff @(posedge clk_sys or negedge rst_n)
		if (!rst_n)
			up <= 2'h0;
		else if (!ce)
			up <= 2'h0;
		else if (up != 2'h3)
			up <= up + 2'h1;
	sequence s_jtag;
		up != 2'h0 && !swd_mode_active && !$past(debug_pin_config);
	endsequence
	property p_b2_timer;
		up != 2'h0 && $past(timer2_remap_option && timer2_channel_output_enable
			&& port_b_low_config[11:8] == 4'h9)
			|-> pin_oe[1] && pin_out[1] == $past(timer2_channel2_out);
	endproperty
	a_b2_timer: assert property (p_b2_timer) else $error("timer not on b2");
	property p_b2_twi;
		up != 2'h0 && $past(serial_ctl1_mode_select == 2'h3 && port_b_low_config[11:8] == 4'hd
			&& !(timer2_remap_option && timer2_channel_output_enable))
			|-> !pin_out[1] && pin_oe[1] == !$past(serial_ctl1_twowire_release);
	endproperty
	a_b2_twi: assert property (p_b2_twi) else $error("two-wire clock wrong");
	property p_c2_tdo;
		s_jtag |-> pin_oe[4] == $past(scan_test_data_out_en) && debug_clock_pull_down
			&& (!pin_oe[4] || pin_out[4] == $past(scan_test_data_out));
	endproperty
	a_c2_tdo: assert property (p_c2_tdo) else $error("scan data out wrong");
	property p_c3_tdi;
		s_jtag |-> !pin_oe[5] && pin_pull_up[5] && !pin_oe[6] && pin_pull_up[6];
	endproperty
	a_c3_tdi: assert property (p_c3_tdi) else $error("scan inputs driven");
	property p_c4_swd;
		up != 2'h0 && swd_mode_active && !$past(debug_pin_config)
			|-> pin_oe[6] == $past(swd_data_oe) && pin_pull_up[6];
	endproperty
	a_c4_swd: assert property (p_c4_swd) else $error("wire data turn wrong");
	property p_clk;
		up == 2'h3 && swd_mode_active == $past(swd_mode_active, 3) && !$past(debug_pin_config)
			|-> swd_mode_active ? swd_clock == $past(debug_clock_pin_in, 3) && !scan_test_clock
			: scan_test_clock == $past(debug_clock_pin_in, 3) && !swd_clock;
	endproperty
	a_clk: assert property (p_clk) else $error("debug clock routed wrong");
	property p_b0_an;
		up != 2'h0 && $past(port_b_low_config[3:0]) == 4'h0 |-> adc_reference_select && !pin_oe[0];
	endproperty
	a_b0_an: assert property (p_b0_an) else $error("b0 analog wrong");
	property p_rst;
		(up == 2'h3 && !external_reset_low) [*6] |-> !swd_mode_active;
	endproperty
	a_rst: assert property (p_rst) else $error("reset pad left wire mode");
	c_swd: cover property ($rose(swd_mode_active));
	c_twi: cover property (p_b2_twi);
	c_tim: cover property (p_b2_timer);
endmodule
bind dpfs_top dpfs_monitor mon (.*);

// ---- dpfs_debugger.sv ----
// Debugger model that clocks a debug port switch code onto the pads
`timescale 1ns/1ps
module dpfs_debugger
(
	input  wire logic        go,    // Rising edge starts a frame
	input  wire logic [15:0] seq,   // Switch code, sent LSB first
	input  wire logic        slow,  // Stretches the clock threefold
	output logic             swclk, // Debug clock, low between frames
	output logic             swdat, // Data level while driving
	output logic             drv,   // Debugger owns the data line
	output logic             busy   // Frame in progress
);
	int h;
	initial
	begin
		swclk = 1'b0;
		swdat = 1'b1;
		drv = 1'b0;
		busy = 1'b0;
	end
	task automatic send(input logic b);
		swdat = b;
		#(h) swclk = 1'b1;
		#(h) swclk = 1'b0;
	endtask
	always @(posedge go)
	begin
		h = slow ? 240 : 80;
		busy = 1'b1;
		drv = 1'b1;
		repeat (56) send(1'b1);
		for (int i = 0; i < 16; i++)
			send(seq[i]);
		drv = 1'b0;
		swdat = ~swdat;
		busy = 1'b0;
	end
endmodule

// ---- tb_top.sv ----
// Self-checking bench for the pin function select block
`timescale 1ns/1ps
module tb_top;
	logic clk_sys, rst_n, ce, debug_clock_pin_in, external_reset_low, ext_interrupt_c_default;
	logic [6:0] pin_out, pin_oe, pin_pull_up, gpio_out, gpio_oe, gpio_in, pr;
	wire [6:0] pin_in;
	logic [15:0] port_b_low_config, port_c_low_config, seq;
	logic [1:0] serial_ctl1_mode_select, trace_mode;
	logic [2:0] irq_c_select, irq_d_select;
	logic debug_clock_pull_down, debug_pin_config, timer2_remap_option;
	logic timer2_channel_output_enable, serial_ctl1_spi_control, trace_enable;
	logic irq_c_select_en, irq_d_select_en, timer2_channel2_out, serial_ctl1_twowire_release;
	logic scan_test_data_out, scan_test_data_out_en, swd_data_out, swd_data_oe;
	logic async_trace_out, sync_trace_clock, sync_trace_bit0, sync_trace_bit1;
	logic serial_ctl1_slave_data_in, serial_ctl1_twowire_clock, serial_ctl1_receive;
	logic timer2_channel2, scan_test_clock, scan_test_data_in, scan_test_mode_select;
	logic scan_test_reset, swd_clock, swd_data_in, swd_mode_active, ext_interrupt_a;
	logic ext_interrupt_c, ext_interrupt_d, timer1_ext_clock, timer2_clock_mask;
	logic adc_reference_select, converter_input_3, go, slow, sd, sdrv, busy;
	logic [3:0] fc [4] = '{4'h0, 4'h9, 4'hd, 4'h4};
	logic [63:0] r;
	int fails, checks_done, n;
	// Debugger releases C4 to a random level, not its last bit
	assign pin_in = {sdrv ? sd : pr[6], pr[5:0]};
	dpfs_top dut (.*);
	dpfs_debugger dbg (.go(go), .seq(seq), .slow(slow), .swclk(debug_clock_pin_in),
		.swdat(sd), .drv(sdrv), .busy(busy));
	initial
	begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	task automatic chk(input logic [15:0] g, e, input string m);
		checks_done++;
		if (g !== e)
		begin
			fails++;
			$display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	function automatic logic [11:0] exp_snk();
		logic b = pr[1];
		logic j = !debug_pin_config;
		return {serial_ctl1_mode_select == 2'h2 && serial_ctl1_spi_control && b,
			serial_ctl1_mode_select != 2'h1 || b, timer2_remap_option && b, {3{pr[0]}},
			port_b_low_config[3:0] == 4'h0, port_c_low_config[7:4] == 4'h0,
			irq_d_select_en ? pr[irq_d_select] : pr[2],
			irq_c_select_en ? pr[irq_c_select] : ext_interrupt_c_default,
			!j || pr[5], !j || pr[6]};
	endfunction
	function automatic logic [1:0] pad(input logic an, al, s, input int i);
		return an ? 2'b00 : al ? {1'b1, s} : {gpio_oe[i], gpio_oe[i] & gpio_out[i]};
	endfunction
	task automatic rnd;
		@(negedge clk_sys);
		r = {$urandom, $urandom};
		{pr, gpio_out, gpio_oe, ext_interrupt_c_default, debug_pin_config, timer2_remap_option,
			timer2_channel_output_enable, serial_ctl1_mode_select, serial_ctl1_spi_control,
			trace_enable, trace_mode, irq_c_select_en, irq_d_select_en, timer2_channel2_out,
			serial_ctl1_twowire_release, scan_test_data_out, scan_test_data_out_en, swd_data_out,
			swd_data_oe, async_trace_out, sync_trace_clock, sync_trace_bit0,
			sync_trace_bit1} = r[42:0];
		port_b_low_config = {4'h4, fc[$urandom % 4], 4'h4, fc[$urandom % 4]};
		port_c_low_config = {4'h4, fc[$urandom % 4], fc[$urandom % 4], fc[$urandom % 4]};
		irq_c_select = 3'($urandom % 7);
		irq_d_select = 3'($urandom % 7);
		repeat (4) @(negedge clk_sys);
		chk({serial_ctl1_slave_data_in, serial_ctl1_receive, timer2_channel2, ext_interrupt_a,
			timer1_ext_clock, timer2_clock_mask, adc_reference_select, converter_input_3,
			ext_interrupt_d, ext_interrupt_c, scan_test_data_in, scan_test_mode_select},
			exp_snk(), "sinks");
		chk({gpio_in, serial_ctl1_twowire_clock}, {pr, !(serial_ctl1_mode_select == 2'h3 &&
			port_b_low_config[11:8] == 4'hd && !(timer2_remap_option &&
			timer2_channel_output_enable)) || pr[1]}, "gpio twi");
		chk({pin_oe[0], pin_oe[0] & pin_out[0], pin_oe[3], pin_oe[3] & pin_out[3]},
			{pad(port_b_low_config[3:0] == 4'h0, trace_enable && port_b_low_config[3:0] == 4'h9,
			sync_trace_clock, 0), pad(port_c_low_config[7:4] == 4'h0, trace_enable
			&& port_c_low_config[7:4] == 4'h9, trace_mode == 2'h0 ? async_trace_out
			: sync_trace_bit0, 3)}, "b0 c1 pads");
		chk({pin_oe[2], scan_test_reset}, (trace_enable && trace_mode[1]) ?
			{port_c_low_config[3:0] == 4'h9 || gpio_oe[2], 1'b1} : {debug_pin_config &
			gpio_oe[2], debug_pin_config | pr[2]}, "c0 pad");
	endtask
	task automatic sw(input logic [15:0] s, input logic sl, e);
		@(negedge clk_sys);
		debug_pin_config = 1'b0;
		seq = s;
		slow = sl;
		go = 1'b1;
		for (n = 0; n < 3000 && (busy || n < 2); n++)
			@(negedge clk_sys);
		if (n == 3000)
		begin
			fails++;
			report_and_stop();
		end
		go = 1'b0;
		repeat (6) @(negedge clk_sys);
		chk(swd_mode_active, e, "mode after switch code");
	endtask
	initial
	begin
		{rst_n, go, slow, seq, pr, gpio_out, gpio_oe, port_b_low_config} = '0;
		{port_c_low_config, debug_pin_config, trace_enable, trace_mode, swd_data_oe} = '0;
		{ext_interrupt_c_default, timer2_remap_option, timer2_channel_output_enable} = '0;
		{serial_ctl1_mode_select, serial_ctl1_spi_control, irq_c_select_en, irq_d_select_en} = '0;
		{irq_c_select, irq_d_select, timer2_channel2_out, serial_ctl1_twowire_release} = '0;
		{scan_test_data_out, scan_test_data_out_en, swd_data_out, async_trace_out} = '0;
		{sync_trace_clock, sync_trace_bit0, sync_trace_bit1} = '0;
		{ce, external_reset_low} = 2'b11;
		n = $urandom(12);
		repeat (4) @(posedge clk_sys);
		@(negedge clk_sys) rst_n = 1'b1;
		repeat (3) @(negedge clk_sys);
		chk(swd_mode_active, 1'b0, "mode after reset");
		repeat (80) rnd();
		$display("random pin routing done");
		sw(16'he79e, 1'b0, 1'b1);
		port_c_low_config = 16'h4944;
		repeat (8)
		begin
			{swd_data_oe, swd_data_out, async_trace_out, trace_enable, gpio_oe, gpio_out} = 18'($urandom);
			trace_mode = 2'h0;
			repeat (2) @(negedge clk_sys);
			chk({pin_oe[6], pin_oe[6] & pin_out[6], pin_oe[4], pin_oe[4] & pin_out[4], pin_oe[5],
				pin_oe[5] & pin_out[5], swd_data_in}, {swd_data_oe, swd_data_oe & swd_data_out,
				pad(1'b0, trace_enable, async_trace_out, 4), gpio_oe[5],
				gpio_oe[5] & gpio_out[5], pr[6]}, "wire mode pads");
		end
		$display("wire mode pads done");
		sw(16'he73c, 1'b1, 1'b0);
		sw(16'he79e, 1'b0, 1'b1);
		external_reset_low = 1'b0;
		repeat (8) @(negedge clk_sys);
		chk(swd_mode_active, 1'b0, "mode after reset pad");
		external_reset_low = 1'b1;
		$display("mode switching done");
		repeat (20) rnd();
		report_and_stop();
	end
endmodule
